// File: host_bus_model.sv
/*
 * host processor model on the channel's parallel register bus.
 * assumes strobes are taken on the rising clock edge, one access at a time.
 */
`timescale 1ns/1ns
module host_bus_model (
	input wire logic i_mclk,
	input wire logic [7:0] i_rdata,
	output logic o_cs_b,
	output logic [2:0] o_addr,
	output logic o_rd,
	output logic o_wr,
	output logic [7:0] o_wdata
);
	initial begin
		o_cs_b = 1'b1;
		o_addr = 3'h0;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 8'h00;
	end
	// one strobe cycle, released address and data lines show inverted values
	task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge i_mclk);
		o_cs_b = 1'b0;
		o_addr = a;
		o_wr = wr;
		o_rd = !wr;
		o_wdata = d;
		@(negedge i_mclk);
		q = i_rdata;
		o_cs_b = 1'b1;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask : access
endmodule : host_bus_model

// File: tb_top.sv
/*
 * self-checking bench for the channel register block.
 * assumes the host model drives the bus and the bench drives datapath status.
 */
`timescale 1ns/1ns
module tb_top;
	import uart_regs_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic cs_b, rd, wr, rx_read, tx_write, ms_read, rx_rst, tx_rst, fifo_en, irq;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, q, tx_data, fifo_ctrl, line_ctrl, modem_ctrl, frac;
	logic [15:0] divisor;
	logic [5:0] rx_level = 6'h00;
	logic [5:0] rx_trig = 6'h04;
	logic ovr = 1'b0, par = 1'b0, fr = 1'b0, brk = 1'b0, any_err = 1'b0, tx_empty = 1'b0, sh_empty = 1'b0;
	logic push = 1'b0, rx_to = 1'b0;
	logic [7:0] modem_st = 8'h00;
	int error_cnt = 0;
	int samples_checked = 0;
	always #20 mclk = ~mclk;
	host_bus_model i_host_bus_model (.i_mclk(mclk), .i_rdata(rdata), .o_cs_b(cs_b), .o_addr(addr), .o_rd(rd),
		.o_wr(wr), .o_wdata(wdata));
	uart_channel_regs #(.LEVEL_W(6)) i_uart_channel_regs (.I_MCLK(mclk), .I_RST_B(rst_b), .I_CS_B(cs_b),
		.I_ADDR(addr), .I_RD(rd), .I_WR(wr), .I_WDATA(wdata), .I_RX_CHAR(8'h3C), .I_RX_LEVEL(rx_level),
		.I_RX_TRIGGER(rx_trig), .I_RX_PUSH(push), .I_RX_OVERRUN(ovr), .I_HEAD_PARITY_ERR(par),
		.I_HEAD_FRAMING_ERR(fr), .I_HEAD_BREAK(brk), .I_RX_ANY_ERR(any_err), .I_RX_TIMEOUT(rx_to),
		.I_TX_EMPTY(tx_empty), .I_TX_SHIFT_EMPTY(sh_empty), .I_MODEM_STATUS(modem_st), .O_RDATA(rdata),
		.O_RX_READ(rx_read), .O_TX_WRITE(tx_write), .O_TX_DATA(tx_data), .O_MODEM_STATUS_READ(ms_read),
		.O_RX_FIFO_RESET(rx_rst), .O_TX_FIFO_RESET(tx_rst), .O_FIFO_EN(fifo_en), .O_FIFO_CTRL(fifo_ctrl),
		.O_LINE_CTRL(line_ctrl), .O_MODEM_CTRL(modem_ctrl), .O_DIVISOR(divisor), .O_DIVISOR_FRACTION(frac),
		.O_IRQ(irq));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		i_host_bus_model.access(1'b1, a, d, q);
	endtask : wreg
	task automatic rchk(input string name, input logic [2:0] a, input logic [7:0] exp);
		i_host_bus_model.access(1'b0, a, 8'h00, q);
		chk(name, {8'h00, exp}, {8'h00, q});
	endtask : rchk
	task automatic report_and_stop;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#200000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(negedge mclk);
		rst_b = 1'b1;
		chk("divisor reset", 16'h0001, divisor);
		wreg(ADDR_LCTL, 8'h03);
		chk("line ctrl", 16'h0003, {8'h00, line_ctrl});
		wreg(ADDR_DATA, 8'h5A);
		chk("tx write", 16'h015A, {7'h00, tx_write, tx_data});
		rchk("rx char", ADDR_DATA, 8'h3C);
		chk("rx read", 16'h0001, {15'h0000, rx_read});
		for (int i = 0; i < 8; i++) begin
			{brk, sh_empty, tx_empty} = 3'(i);
			fr = sh_empty;
			par = tx_empty ^ brk;
			any_err = tx_empty;
			rx_level = {5'h00, brk};
			rchk("line status", ADDR_LSTAT, {any_err, tx_empty & sh_empty, tx_empty, brk, fr, par, 1'b0, brk});
		end
		{brk, fr, par, any_err, rx_level} = '0;
		ovr = 1'b1;
		@(negedge mclk);
		ovr = 1'b0;
		rchk("overrun set", ADDR_LSTAT, 8'h62);
		rchk("overrun clear", ADDR_LSTAT, 8'h60);
		wreg(ADDR_IDENT, 8'h01);
		wreg(ADDR_IDENT, 8'h07);
		chk("fifo resets", 16'h0701, {5'h00, fifo_en, rx_rst, tx_rst, fifo_ctrl});
		wreg(ADDR_MASK, 8'hF1);
		rchk("mask gated", ADDR_MASK, 8'h01);
		wreg(ADDR_MCTL, 8'h08);
		chk("modem ctrl", 16'h0008, {8'h00, modem_ctrl});
		rx_level = 6'h03;
		rchk("below trigger", ADDR_IDENT, 8'hC1);
		chk("irq low", 16'h0000, {15'h0000, irq});
		rx_level = 6'h04;
		rchk("at trigger", ADDR_IDENT, 8'hC4);
		chk("irq high", 16'h0001, {15'h0000, irq});
		rx_level = 6'h03;
		rchk("dropped", ADDR_IDENT, 8'hC1);
		chk("irq dropped", 16'h0000, {15'h0000, irq});
		rx_level = 6'h04;
		wreg(ADDR_MCTL, 8'h00);
		@(negedge mclk);
		chk("irq gated", 16'h0000, {15'h0000, irq});
		wreg(ADDR_MCTL, 8'h08);
		wreg(ADDR_MASK, 8'h03);
		rchk("rx over tx", ADDR_IDENT, 8'hC4);
		rx_level = 6'h03;
		rchk("tx queued", ADDR_IDENT, 8'hC2);
		rchk("tx cleared", ADDR_IDENT, 8'hC1);
		wreg(ADDR_MASK, 8'h00);
		rx_level = 6'h04;
		rchk("polled ident", ADDR_IDENT, 8'hC1);
		rchk("polled status", ADDR_LSTAT, 8'h61);
		wreg(ADDR_MASK, 8'h04);
		ovr = 1'b1;
		@(negedge mclk);
		ovr = 1'b0;
		rchk("line pending", ADDR_IDENT, 8'hC6);
		rchk("line status rd", ADDR_LSTAT, 8'h63);
		rchk("line cleared", ADDR_IDENT, 8'hC1);
		par = 1'b1;
		push = 1'b1;
		@(negedge mclk);
		push = 1'b0;
		rchk("error pending", ADDR_IDENT, 8'hC6);
		rchk("error status", ADDR_LSTAT, 8'h65);
		par = 1'b0;
		wreg(ADDR_MASK, 8'h08);
		modem_st = 8'h01;
		rchk("modem pending", ADDR_IDENT, 8'hC0);
		rchk("modem status", ADDR_MSTAT, 8'h01);
		chk("modem read", 16'h0001, {15'h0000, ms_read});
		modem_st = 8'h00;
		wreg(ADDR_MASK, 8'h01);
		rx_to = 1'b1;
		rchk("timeout", ADDR_IDENT, 8'hCC);
		rx_to = 1'b0;
		wreg(ADDR_LCTL, 8'h80);
		wreg(ADDR_DATA, 8'h34);
		wreg(ADDR_MASK, 8'h12);
		chk("divisor", 16'h1234, divisor);
		wreg(ADDR_IDENT, 8'h2A);
		chk("fraction locked", 16'h0000, {8'h00, frac});
		wreg(ADDR_LCTL, ENH_KEY);
		wreg(ADDR_IDENT, 8'h10);
		rchk("enhanced", ADDR_IDENT, 8'h10);
		wreg(ADDR_LCTL, 8'h80);
		wreg(ADDR_IDENT, 8'h2A);
		chk("fraction", 16'h002A, {8'h00, frac});
		wreg(ADDR_LCTL, 8'h03);
		wreg(ADDR_MASK, 8'hF0);
		rchk("mask enhanced", ADDR_MASK, 8'hF0);
		report_and_stop();
	end
endmodule : tb_top
bind uart_channel_regs uart_channel_props #(.LEVEL_W(LEVEL_W)) i_uart_channel_props (.*);

// File: uart_channel_props.sv
/*
 * port checker for the channel register block.
 * assumes it is bound to the block's top ports, one clock domain.
 */
`timescale 1ns/1ns
module uart_channel_props #(
	parameter int LEVEL_W = 6
) (
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	input wire logic I_CS_B,
	input wire logic [2:0] I_ADDR,
	input wire logic I_RD,
	input wire logic I_WR,
	input wire logic [7:0] I_WDATA,
	input wire logic [LEVEL_W-1:0] I_RX_LEVEL,
	input wire logic I_RX_OVERRUN,
	input wire logic I_HEAD_PARITY_ERR,
	input wire logic I_HEAD_FRAMING_ERR,
	input wire logic I_HEAD_BREAK,
	input wire logic I_RX_ANY_ERR,
	input wire logic I_TX_EMPTY,
	input wire logic I_TX_SHIFT_EMPTY,
	input wire logic [7:0] O_RDATA,
	input wire logic O_TX_WRITE,
	input wire logic [7:0] O_TX_DATA,
	input wire logic [7:0] O_LINE_CTRL,
	input wire logic [7:0] O_MODEM_CTRL,
	input wire logic [15:0] O_DIVISOR,
	input wire logic O_IRQ
);
	wire sel_wr = !I_CS_B && I_WR;
	wire status_rd = !I_CS_B && I_RD && I_ADDR == 3'h5 && !O_LINE_CTRL[7];
	wire div_on = O_LINE_CTRL[7] && O_LINE_CTRL != 8'hBF;
	wire tx_both = I_TX_EMPTY && I_TX_SHIFT_EMPTY;
	wire lvl_nz = I_RX_LEVEL != '0;
	wire [2:0] head_err = {I_HEAD_BREAK, I_HEAD_FRAMING_ERR, I_HEAD_PARITY_ERR};
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);
	tx_write_a: assert property (
		sel_wr && I_ADDR == 3'h0 && !O_LINE_CTRL[7] |=> O_TX_WRITE && O_TX_DATA == $past(I_WDATA))
		else $error("transmit write not forwarded");
	irq_gate_a: assert property (
		!O_MODEM_CTRL[3] && !$past(O_MODEM_CTRL[3]) |-> !O_IRQ) else $error("interrupt driven while disabled");
	tx_status_a: assert property (
		status_rd |=> O_RDATA[6:5] == {$past(tx_both), $past(I_TX_EMPTY)}) else $error("transmit status wrong");
	data_ready_a: assert property (
		status_rd |=> O_RDATA[0] == $past(lvl_nz)) else $error("data ready wrong");
	rx_overrun_a: assert property (
		I_RX_OVERRUN ##1 !status_rd ##1 status_rd |=> O_RDATA[1]) else $error("overrun not reported");
	err_bits_a: assert property (
		status_rd |=> O_RDATA[4:2] == $past(head_err)) else $error("head error bits wrong");
	global_err_a: assert property (
		status_rd |=> O_RDATA[7] == $past(I_RX_ANY_ERR)) else $error("global error bit wrong");
	divisor_low_a: assert property (
		sel_wr && I_ADDR == 3'h0 && div_on |=> O_DIVISOR[7:0] == $past(I_WDATA) && !O_TX_WRITE)
		else $error("divisor low not written");
	cover property (status_rd);
	cover property ($rose(O_IRQ));
	cover property (sel_wr && div_on);
endmodule : uart_channel_props

// File: uart_channel_regs.sv
/*
 * register map, interrupt masking and line status of one serial channel.
 * assumes the datapaths outside report FIFO levels, error tags and
 * strobes synchronous to I_MCLK; host strobes are one-cycle pulses.
 */
//
// Behaviour
// RL1 - interrupt mask gates rx data, tx empty, line status, modem sources into identification
// RL2 - fifo mode, rx interrupt enabled: raise at trigger level, drop below it
// RL3 - identification code and interrupt output both follow the trigger condition
// RL4 - data ready sets when a character enters the fifo, clears when empty
// RL5 - host enables fifo and clears mask bits 0-3 for polled mode
// RL6 - line status keeps separate receive and transmit bits
// RL7 - line status bit 1 set on receive overrun
// RL8 - bits 2-4 show parity, framing, break of the character at the head
// RL9 - bit 5 high when transmit holding register or fifo is empty
// RL10 - bit 6 high only when transmit fifo and shift register are empty
// RL11 - bit 7 set while any stored character carries an error tag
// RL12 - enhanced enable gates writes to the enhanced bits and fractional divisor; a fifo control write with bit 0 clear zeroes bits 4-5 regardless
// RL13 - fractional divisor reached only with divisor bit set, not key, enhanced enabled
// RL14 - modem control bit 3 enables the interrupt output pin
// RL15 - each channel has its own registers, chosen by select and three address lines
// RL16 - identification shows the highest pending source, lower ones stay queued
// RL17 - reading line status clears a pending line status interrupt
// RL18 - data offset reads received character, writes transmit holding register
// RL19 - divisor bit set and not key: offsets 0 and 1 reach divisor bytes
`timescale 1ns/1ns
module uart_channel_regs
	import uart_regs_pkg::*;
#(
	parameter int LEVEL_W = 6
) (
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	input wire logic I_CS_B,
	input wire logic [2:0] I_ADDR,
	input wire logic I_RD,
	input wire logic I_WR,
	input wire logic [7:0] I_WDATA,
	input wire logic [7:0] I_RX_CHAR,
	input wire logic [LEVEL_W-1:0] I_RX_LEVEL,
	input wire logic [LEVEL_W-1:0] I_RX_TRIGGER,
	input wire logic I_RX_PUSH,
	input wire logic I_RX_OVERRUN,
	input wire logic I_HEAD_PARITY_ERR,
	input wire logic I_HEAD_FRAMING_ERR,
	input wire logic I_HEAD_BREAK,
	input wire logic I_RX_ANY_ERR,
	input wire logic I_RX_TIMEOUT,
	input wire logic I_TX_EMPTY,
	input wire logic I_TX_SHIFT_EMPTY,
	input wire logic [7:0] I_MODEM_STATUS,
	output logic [7:0] O_RDATA,
	output logic O_RX_READ,
	output logic O_TX_WRITE,
	output logic [7:0] O_TX_DATA,
	output logic O_MODEM_STATUS_READ,
	output logic O_RX_FIFO_RESET,
	output logic O_TX_FIFO_RESET,
	output logic O_FIFO_EN,
	output logic [7:0] O_FIFO_CTRL,
	output logic [7:0] O_LINE_CTRL,
	output logic [7:0] O_MODEM_CTRL,
	output logic [15:0] O_DIVISOR,
	output logic [7:0] O_DIVISOR_FRACTION,
	output logic O_IRQ
);

	function automatic logic [7:0] gated(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] enh_bits, input logic enh);
		gated = enh ? new_v : ((new_v & ~enh_bits) | (old_v & enh_bits));
	endfunction : gated

	logic [7:0] interrupt_mask, next_interrupt_mask;
	logic [7:0] fifo_control, next_fifo_control;
	logic [7:0] line_control, next_line_control;
	logic [7:0] modem_control, next_modem_control;
	logic [7:0] scratch_pad, next_scratch_pad;
	logic [7:0] baud_divisor_low, next_baud_divisor_low;
	logic [7:0] baud_divisor_high, next_baud_divisor_high;
	logic [7:0] baud_divisor_fraction, next_baud_divisor_fraction;
	logic [7:0] enhanced_feature, next_enhanced_feature;
	logic [7:0] resume_char_first, next_resume_char_first;
	logic [7:0] resume_char_second, next_resume_char_second;
	logic [7:0] pause_char_first, next_pause_char_first;
	logic [7:0] pause_char_second, next_pause_char_second;
	logic overrun, next_overrun;
	logic line_pend, next_line_pend;
	logic tx_pend, next_tx_pend;
	logic tx_empty_q;
	logic [7:0] rdata, next_rdata;
	logic rx_read, tx_write, modem_status_read, rxrst, txrst, irq;
	logic [7:0] tx_data;

	logic sel, rd, wr, enh_bank, div_bank, frac_ok, enh;
	logic rx_data_ready, fifo_on, rx_trig;
	logic [7:0] line_status, ident;
	src_type src;

	always_comb begin
		sel = !I_CS_B; // RL15
		rd = sel && I_RD;
		wr = sel && I_WR;
		enh = enhanced_feature[ENHANCED_EN_BIT];
		enh_bank = (line_control == ENH_KEY);
		div_bank = line_control[DIVISOR_BANK_BIT] && !enh_bank; // RL19
		frac_ok = div_bank && enh; // RL13
		fifo_on = fifo_control[FIFO_EN_BIT];
		rx_data_ready = (I_RX_LEVEL != '0); // RL4
		rx_trig = fifo_on ? (I_RX_LEVEL >= I_RX_TRIGGER) : rx_data_ready; // RL2
		line_status = {I_RX_ANY_ERR, // RL11
			I_TX_EMPTY && I_TX_SHIFT_EMPTY, // RL10
			I_TX_EMPTY, // RL9
			I_HEAD_BREAK, I_HEAD_FRAMING_ERR, I_HEAD_PARITY_ERR, // RL8
			overrun, // RL7
			rx_data_ready}; // RL6
		// fixed priority; lower sources stay pending
		if (interrupt_mask[MASK_LINE_BIT] && line_pend) begin // RL16
			src = SEL_LINE;
		end else if (interrupt_mask[MASK_RX_BIT] && I_RX_TIMEOUT) begin
			src = SEL_TIMEOUT;
		end else if (interrupt_mask[MASK_RX_BIT] && rx_trig) begin // RL1
			src = SEL_RXDATA;
		end else if (interrupt_mask[MASK_TX_BIT] && tx_pend) begin
			src = SEL_TXRDY;
		end else if (interrupt_mask[MASK_MODEM_BIT] && ((I_MODEM_STATUS & MODEM_DELTA_BITS) != ZERO_BYTE)) begin
			src = SEL_MODEM;
		end else begin
			src = SEL_NONE;
		end
		ident = {fifo_on, fifo_on, 2'b00, SRC_NONE};
		case (src)
			SEL_LINE: ident[3:0] = SRC_LINE;
			SEL_TIMEOUT: ident[3:0] = SRC_TIMEOUT;
			SEL_RXDATA: ident[3:0] = SRC_RXDATA; // RL3
			SEL_TXRDY: ident[3:0] = SRC_TXRDY;
			SEL_MODEM: ident[3:0] = SRC_MODEM;
			default: ident[3:0] = SRC_NONE;
		endcase
	end

	always_comb begin
		next_interrupt_mask = interrupt_mask;
		next_fifo_control = fifo_control;
		next_line_control = line_control;
		next_modem_control = modem_control;
		next_scratch_pad = scratch_pad;
		next_baud_divisor_low = baud_divisor_low;
		next_baud_divisor_high = baud_divisor_high;
		next_baud_divisor_fraction = baud_divisor_fraction;
		next_enhanced_feature = enhanced_feature;
		next_resume_char_first = resume_char_first;
		next_resume_char_second = resume_char_second;
		next_pause_char_first = pause_char_first;
		next_pause_char_second = pause_char_second;
		next_rdata = rdata;
		next_overrun = overrun;
		next_line_pend = line_pend;
		next_tx_pend = tx_pend;
		// line status read clears, new event wins
		if (rd && I_ADDR == ADDR_LSTAT && !enh_bank) begin // RL17
			next_overrun = 1'b0;
			next_line_pend = 1'b0;
		end
		if (I_RX_OVERRUN) begin
			next_overrun = 1'b1;
		end
		// identification read services only the tx ready source, and only when it is the source shown
		if (rd && I_ADDR == ADDR_IDENT && !line_control[DIVISOR_BANK_BIT] && src == SEL_TXRDY) begin // RL16
			next_tx_pend = 1'b0;
		end
		if (wr && I_ADDR == ADDR_DATA && !line_control[DIVISOR_BANK_BIT]) begin
			next_tx_pend = 1'b0;
		end
		if (I_TX_EMPTY && !tx_empty_q) begin
			next_tx_pend = 1'b1;
		end
		if (I_RX_OVERRUN || (I_RX_PUSH && (I_HEAD_PARITY_ERR || I_HEAD_FRAMING_ERR || I_HEAD_BREAK))) begin
			next_line_pend = 1'b1;
		end
		// register writes, by bank
		if (wr) begin
			case (I_ADDR)
				ADDR_DATA: begin
					if (div_bank) begin
						next_baud_divisor_low = I_WDATA; // RL19
					end
				end
				ADDR_MASK: begin
					if (div_bank) begin
						next_baud_divisor_high = I_WDATA;
					end else if (!enh_bank) begin
						next_interrupt_mask = gated(interrupt_mask, I_WDATA, MASK_ENH_BITS, enh); // RL12
						if (I_WDATA[MASK_TX_BIT] && I_TX_EMPTY) begin
							next_tx_pend = 1'b1;
						end
					end
				end
				ADDR_IDENT: begin
					if (enh_bank) begin
						next_enhanced_feature = I_WDATA;
					end else if (frac_ok) begin
						next_baud_divisor_fraction = I_WDATA & FRACTION_BITS; // RL13
					end else if (!line_control[DIVISOR_BANK_BIT]) begin
						if (I_WDATA[FIFO_EN_BIT]) begin
							next_fifo_control = gated(fifo_control, I_WDATA, FIFO_ENH_BITS, enh); // RL12
							next_fifo_control[RX_FIFO_RST_BIT] = 1'b0;
							next_fifo_control[TX_FIFO_RST_BIT] = 1'b0;
						end else begin
							next_fifo_control = ZERO_BYTE;
						end
					end
				end
				ADDR_LCTL: next_line_control = I_WDATA;
				ADDR_MCTL: begin
					if (enh_bank) begin
						next_resume_char_first = I_WDATA;
					end else begin
						next_modem_control = gated(modem_control, I_WDATA, MODEM_ENH_BITS, enh); // RL12
					end
				end
				ADDR_LSTAT: begin
					if (enh_bank) begin
						next_resume_char_second = I_WDATA;
					end
				end
				ADDR_MSTAT: begin
					if (enh_bank) begin
						next_pause_char_first = I_WDATA;
					end
				end
				ADDR_SCRATCH: begin
					if (enh_bank) begin
						next_pause_char_second = I_WDATA;
					end else begin
						next_scratch_pad = I_WDATA;
					end
				end
				default: next_scratch_pad = scratch_pad;
			endcase
		end
		// read data, by bank
		if (rd) begin
			case (I_ADDR)
				ADDR_DATA: next_rdata = div_bank ? baud_divisor_low : I_RX_CHAR; // RL18
				ADDR_MASK: next_rdata = div_bank ? baud_divisor_high : interrupt_mask;
				ADDR_IDENT: begin
					if (enh_bank) begin
						next_rdata = enhanced_feature;
					end else if (frac_ok) begin
						next_rdata = baud_divisor_fraction;
					end else begin
						next_rdata = ident; // RL16
					end
				end
				ADDR_LCTL: next_rdata = line_control;
				ADDR_MCTL: next_rdata = enh_bank ? resume_char_first : modem_control;
				ADDR_LSTAT: next_rdata = enh_bank ? resume_char_second : line_status;
				ADDR_MSTAT: next_rdata = enh_bank ? pause_char_first : I_MODEM_STATUS;
				ADDR_SCRATCH: next_rdata = enh_bank ? pause_char_second : scratch_pad;
				default: next_rdata = ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			interrupt_mask <= ZERO_BYTE;
			fifo_control <= ZERO_BYTE;
			line_control <= ZERO_BYTE;
			modem_control <= ZERO_BYTE;
			scratch_pad <= ZERO_BYTE;
			baud_divisor_low <= DIV_LOW_RESET;
			baud_divisor_high <= ZERO_BYTE;
			baud_divisor_fraction <= ZERO_BYTE;
			enhanced_feature <= ZERO_BYTE;
			resume_char_first <= ZERO_BYTE;
			resume_char_second <= ZERO_BYTE;
			pause_char_first <= ZERO_BYTE;
			pause_char_second <= ZERO_BYTE;
			rdata <= ZERO_BYTE;
			overrun <= 1'b0;
			line_pend <= 1'b0;
			tx_pend <= 1'b0;
			tx_empty_q <= 1'b1;
			rx_read <= 1'b0;
			tx_write <= 1'b0;
			tx_data <= ZERO_BYTE;
			modem_status_read <= 1'b0;
			rxrst <= 1'b0;
			txrst <= 1'b0;
			irq <= 1'b0;
		end else begin
			interrupt_mask <= next_interrupt_mask;
			fifo_control <= next_fifo_control;
			line_control <= next_line_control;
			modem_control <= next_modem_control;
			scratch_pad <= next_scratch_pad;
			baud_divisor_low <= next_baud_divisor_low;
			baud_divisor_high <= next_baud_divisor_high;
			baud_divisor_fraction <= next_baud_divisor_fraction;
			enhanced_feature <= next_enhanced_feature;
			resume_char_first <= next_resume_char_first;
			resume_char_second <= next_resume_char_second;
			pause_char_first <= next_pause_char_first;
			pause_char_second <= next_pause_char_second;
			rdata <= next_rdata;
			overrun <= next_overrun;
			line_pend <= next_line_pend;
			tx_pend <= next_tx_pend;
			tx_empty_q <= I_TX_EMPTY;
			// one-cycle strobes to the datapaths
			rx_read <= rd && I_ADDR == ADDR_DATA && !line_control[DIVISOR_BANK_BIT]; // RL18
			tx_write <= wr && I_ADDR == ADDR_DATA && !line_control[DIVISOR_BANK_BIT]; // RL18
			if (wr && I_ADDR == ADDR_DATA && !line_control[DIVISOR_BANK_BIT]) begin
				tx_data <= I_WDATA;
			end
			modem_status_read <= rd && I_ADDR == ADDR_MSTAT && !enh_bank;
			rxrst <= wr && I_ADDR == ADDR_IDENT && !line_control[DIVISOR_BANK_BIT] && I_WDATA[FIFO_EN_BIT]
				&& I_WDATA[RX_FIFO_RST_BIT];
			txrst <= wr && I_ADDR == ADDR_IDENT && !line_control[DIVISOR_BANK_BIT] && I_WDATA[FIFO_EN_BIT]
				&& I_WDATA[TX_FIFO_RST_BIT];
			// interrupt pin gate
			irq <= (src != SEL_NONE) && modem_control[IRQ_OUT_EN_BIT]; // RL14
		end
	end

	assign O_RDATA = rdata;
	assign O_RX_READ = rx_read;
	assign O_TX_WRITE = tx_write;
	assign O_TX_DATA = tx_data;
	assign O_MODEM_STATUS_READ = modem_status_read;
	assign O_RX_FIFO_RESET = rxrst;
	assign O_TX_FIFO_RESET = txrst;
	assign O_FIFO_EN = fifo_control[FIFO_EN_BIT];
	assign O_FIFO_CTRL = fifo_control;
	assign O_LINE_CTRL = line_control;
	assign O_MODEM_CTRL = modem_control;
	assign O_DIVISOR = {baud_divisor_high, baud_divisor_low};
	assign O_DIVISOR_FRACTION = baud_divisor_fraction;
	assign O_IRQ = irq;

endmodule : uart_channel_regs

// File: uart_regs_pkg.sv
/*
 * constants for one serial channel's register map and status logic.
 * assumes a host bus with three address lines and a single device clock.
 */
package uart_regs_pkg;
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_MASK = 3'h1;
	localparam logic [2:0] ADDR_IDENT = 3'h2;
	localparam logic [2:0] ADDR_LCTL = 3'h3;
	localparam logic [2:0] ADDR_MCTL = 3'h4;
	localparam logic [2:0] ADDR_LSTAT = 3'h5;
	localparam logic [2:0] ADDR_MSTAT = 3'h6;
	localparam logic [2:0] ADDR_SCRATCH = 3'h7;
	localparam logic [7:0] ENH_KEY = 8'hBF;
	localparam int DIVISOR_BANK_BIT = 7;
	localparam int ENHANCED_EN_BIT = 4;
	localparam int IRQ_OUT_EN_BIT = 3;
	localparam int FIFO_EN_BIT = 0;
	localparam int RX_FIFO_RST_BIT = 1;
	localparam int TX_FIFO_RST_BIT = 2;
	localparam int MASK_RX_BIT = 0;
	localparam int MASK_TX_BIT = 1;
	localparam int MASK_LINE_BIT = 2;
	localparam int MASK_MODEM_BIT = 3;
	localparam logic [7:0] MASK_ENH_BITS = 8'hF0;
	localparam logic [7:0] FIFO_ENH_BITS = 8'h30;
	localparam logic [7:0] MODEM_ENH_BITS = 8'hE0;
	localparam logic [7:0] FRACTION_BITS = 8'h3F;
	localparam logic [7:0] MODEM_DELTA_BITS = 8'h0F;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] DIV_LOW_RESET = 8'h01;
	localparam logic [3:0] SRC_LINE = 4'h6;
	localparam logic [3:0] SRC_TIMEOUT = 4'hC;
	localparam logic [3:0] SRC_RXDATA = 4'h4;
	localparam logic [3:0] SRC_TXRDY = 4'h2;
	localparam logic [3:0] SRC_MODEM = 4'h0;
	localparam logic [3:0] SRC_NONE = 4'h1;
	typedef enum logic [2:0] {SEL_NONE, SEL_LINE, SEL_TIMEOUT, SEL_RXDATA, SEL_TXRDY, SEL_MODEM} src_type;
endpackage : uart_regs_pkg
